/* fpx_exec_unit.sv */
// Floating point execution unit: register file, issue interlock, result pipeline
`timescale 1ns/1ps
`include "fpx_regs.svh"

// Summary of operation
// - Thirty-two floating point registers hold operands and results, 64 bits wide or 32 bits in narrow mode.
// - Data follows the IEEE binary single and double formats for sign, exponent, fraction and NaN handling.
// - Abs, negate, add, subtract, compare and single multiply have latency 4 and issue every cycle.
// - Fused multiply-add and multiply-subtract round the product before the addition.
// - Denormal results of arithmetic are replaced by signed zero when flush-to-zero is selected.
// - The unit pipeline keeps advancing whatever the integer pipeline does.
// - Arithmetic issues and completes in program order, while loads may complete out of order.
// - Exceptions are precise: the faulting result and every younger entry still in the result pipeline are discarded.
// - Issue honours both the latency to dependants and the repeat spacing of each instruction.
// - Double multiply and double fused multiply-add forms have latency 5 and repeat 2.
// - Divide and square root take 17/14 cycles in single and 32/29 cycles in double precision.
// - Moves, conditional moves and conversions have latency 4 and repeat 1.
// - Transfers out take 1 cycle latency and repeat, transfers in take 4 cycles latency.
module fpx_exec_unit (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Mode
  input  wire logic             fr64_mode,
  input  wire logic             ftz_en,
  // Issue from the integer core
  input  wire logic             iss_valid,
  input  wire fpx_pkg::fpx_op_t iss_op,
  input  wire logic             iss_dbl,
  input  wire logic [4:0]       iss_fd,
  input  wire logic [4:0]       iss_fs,
  input  wire logic [4:0]       iss_ft,
  input  wire logic [63:0]      iss_int_data,
  output logic                  iss_ready_r,
  // Transfer out to the integer core
  output logic                  out_valid_r,
  output logic [63:0]           out_data_r,
  // Condition codes and exceptions
  output logic [7:0]            cc_r,
  output logic                  exc_r,
  output logic [1:0]            exc_cause_r,
  input  wire logic             exc_clr
);
  logic [63:0]           rf_r   [0:`FPX_NUM_FPR-1];
  logic [5:0]            sb_r   [0:`FPX_NUM_FPR-1];
  logic                  pv_r   [0:`FPX_PIPE_TOP];
  logic                  pw_r   [0:`FPX_PIPE_TOP];
  logic                  pc_r   [0:`FPX_PIPE_TOP];
  logic [1:0]            pe_r   [0:`FPX_PIPE_TOP];
  logic [4:0]            pd_r   [0:`FPX_PIPE_TOP];
  logic [63:0]           px_r   [0:`FPX_PIPE_TOP];
  logic                  hold_v_r;
  fpx_pkg::fpx_op_t      hold_op_r;
  logic                  hold_dbl_r;
  logic [4:0]            hold_fd_r, hold_fs_r, hold_ft_r;
  logic [63:0]           hold_int_r;
  logic [5:0]            ord_r;
  fpx_pkg::fpx_op_t      s_op;
  logic                  s_v, s_dbl, go, arith, wr_reg, to_pipe, out_op, is_cmp, wb_exc;
  logic [4:0]            s_fd, s_fs, s_ft;
  logic [63:0]           s_int, a, b, c, res, sgn;
  logic [5:0]            lat;
  logic [2:0]            cls;
  logic [1:0]            cause;
  logic [`FPX_NUM_CLS-1:0] rpt_busy;

  function automatic logic [5:0] lat_of(input fpx_pkg::fpx_op_t op, input logic dbl);
    case (op)
      fpx_pkg::FPX_OP_MUL, fpx_pkg::FPX_OP_FMA, fpx_pkg::FPX_OP_FMS:
        lat_of = dbl ? `FPX_LAT_MULD : `FPX_LAT_BASIC;
      fpx_pkg::FPX_OP_DIV, fpx_pkg::FPX_OP_SQRT:
        lat_of = dbl ? `FPX_LAT_DIVD : `FPX_LAT_DIVS;
      fpx_pkg::FPX_OP_RECIP: lat_of = dbl ? `FPX_LAT_RCPD : `FPX_LAT_RCPS;
      fpx_pkg::FPX_OP_RSQRT: lat_of = dbl ? `FPX_LAT_RSQD : `FPX_LAT_RSQS;
      fpx_pkg::FPX_OP_MTC, fpx_pkg::FPX_OP_LOAD: lat_of = `FPX_LAT_XFER_IN;
      fpx_pkg::FPX_OP_MFC, fpx_pkg::FPX_OP_STORE: lat_of = `FPX_LAT_XFER_OUT;
      default: lat_of = `FPX_LAT_BASIC;
    endcase
  endfunction

  // Class index of an operation that cannot repeat every cycle
  function automatic logic [2:0] cls_of(input fpx_pkg::fpx_op_t op, input logic dbl);
    case (op)
      fpx_pkg::FPX_OP_MUL, fpx_pkg::FPX_OP_FMA, fpx_pkg::FPX_OP_FMS:
        cls_of = dbl ? 3'h0 : `FPX_CLS_NONE;
      fpx_pkg::FPX_OP_DIV, fpx_pkg::FPX_OP_SQRT: cls_of = dbl ? 3'h2 : 3'h1;
      fpx_pkg::FPX_OP_RECIP: cls_of = dbl ? 3'h4 : 3'h3;
      fpx_pkg::FPX_OP_RSQRT: cls_of = dbl ? 3'h6 : 3'h5;
      default: cls_of = `FPX_CLS_NONE;
    endcase
  endfunction

  function automatic logic [4:0] rpt_of(input int idx);
    case (idx)
      0: rpt_of = `FPX_RPT_MULD;
      1: rpt_of = `FPX_RPT_DIVS;
      2: rpt_of = `FPX_RPT_DIVD;
      3: rpt_of = `FPX_RPT_RCPS;
      4: rpt_of = `FPX_RPT_RCPD;
      5: rpt_of = `FPX_RPT_RSQS;
      6: rpt_of = `FPX_RPT_RSQD;
      default: rpt_of = `FPX_RPT_ONE;
    endcase
  endfunction

  function automatic logic is_nan(input logic [63:0] x, input logic dbl, input logic sig);
    if (dbl) is_nan = (&x[62:52]) && (x[51:0] != 52'h0) && (sig ? !x[51] : 1'b1);
    else     is_nan = (&x[30:23]) && (x[22:0] != 23'h0) && (sig ? !x[22] : 1'b1);
  endfunction

  function automatic logic [62:0] mag_of(input logic [63:0] x, input logic dbl);
    mag_of = dbl ? x[62:0] : {32'h0000_0000, x[30:0]};
  endfunction

  // Issue source: a held instruction always goes before a new one
  assign s_v   = hold_v_r | (iss_valid & iss_ready_r);
  assign s_op  = hold_v_r ? hold_op_r  : iss_op;
  assign s_dbl = hold_v_r ? hold_dbl_r : iss_dbl;
  assign s_fd  = hold_v_r ? hold_fd_r  : iss_fd;
  assign s_fs  = hold_v_r ? hold_fs_r  : iss_fs;
  assign s_ft  = hold_v_r ? hold_ft_r  : iss_ft;
  assign s_int = hold_v_r ? hold_int_r : iss_int_data;

  assign lat     = lat_of(s_op, s_dbl);
  assign cls     = cls_of(s_op, s_dbl);
  assign out_op  = (s_op == fpx_pkg::FPX_OP_MFC) || (s_op == fpx_pkg::FPX_OP_STORE);
  assign is_cmp  = (s_op == fpx_pkg::FPX_OP_CEQ) || (s_op == fpx_pkg::FPX_OP_CLT);
  assign arith   = !out_op && (s_op != fpx_pkg::FPX_OP_MTC) && (s_op != fpx_pkg::FPX_OP_LOAD);
  assign to_pipe = !out_op;
  assign wr_reg  = to_pipe && !is_cmp;
  assign wb_exc  = pv_r[0] && (pe_r[0] != `FPX_EXC_NONE);
  // Forward the entry at writeback so a dependant issues exactly its latency after the producer
  assign a = (pv_r[0] && pw_r[0] && (pd_r[0] == s_fs)) ? px_r[0] : rf_r[s_fs];
  assign b = (pv_r[0] && pw_r[0] && (pd_r[0] == s_ft)) ? px_r[0] : rf_r[s_ft];
  assign c = (pv_r[0] && pw_r[0] && (pd_r[0] == s_fd)) ? px_r[0] : rf_r[s_fd];
  assign sgn = s_dbl ? `FPX_SIGN_D : `FPX_SIGN_S;

  // Interlock: operands ready, slot free, program order, repeat spacing, no exception pending
  assign go = s_v && !exc_r && !wb_exc
           && (sb_r[s_fs] <= 6'h01) && (sb_r[s_ft] <= 6'h01) && (sb_r[s_fd] <= 6'h01)
           && !(to_pipe && pv_r[lat])
           && !(arith && (lat < ord_r))
           && !((cls != `FPX_CLS_NONE) && rpt_busy[cls]);

  genvar g;
  generate
    for (g = 0; g < `FPX_NUM_CLS; g = g + 1) begin : g_rpt
      fpx_rpt_timer u_rpt (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (go && (cls == 3'(g))),
        .load_val (rpt_of(g) - 5'h01),
        .busy     (rpt_busy[g])
      );
    end
  endgenerate

  // Exception detection at issue, reported only when the entry reaches writeback
  always_comb begin
    cause = `FPX_EXC_NONE;
    if (arith && (is_nan(a, s_dbl, 1'b1) || is_nan(b, s_dbl, 1'b1))) begin
      cause = `FPX_EXC_INVALID;
    end else if ((s_op == fpx_pkg::FPX_OP_DIV) && (mag_of(b, s_dbl) == 63'h0) && !is_nan(a, s_dbl, 1'b0)) begin
      cause = `FPX_EXC_DIVZERO;
    end
  end

  // Result datapath
  always_comb begin
    res = s_dbl ? `FPX_QNAN_D : `FPX_QNAN_S;
    case (s_op)
      fpx_pkg::FPX_OP_ABS:  res = a & ~sgn;
      fpx_pkg::FPX_OP_NEG:  res = a ^ sgn;
      fpx_pkg::FPX_OP_MOV:  res = a;
      fpx_pkg::FPX_OP_MOVZ: res = (s_int == `FPX_ZERO64) ? a : c;
      fpx_pkg::FPX_OP_MOVN: res = (s_int != `FPX_ZERO64) ? a : c;
      fpx_pkg::FPX_OP_MTC, fpx_pkg::FPX_OP_LOAD: res = s_dbl ? s_int : (s_int & `FPX_HI_MASK);
      fpx_pkg::FPX_OP_CEQ: begin
        res = `FPX_ZERO64;
        res[0] = !is_nan(a, s_dbl, 1'b0) && !is_nan(b, s_dbl, 1'b0)
              && ((a == b) || ((mag_of(a, s_dbl) == 63'h0) && (mag_of(b, s_dbl) == 63'h0)));
      end
      fpx_pkg::FPX_OP_CLT: begin
        res = `FPX_ZERO64;
        res[0] = !is_nan(a, s_dbl, 1'b0) && !is_nan(b, s_dbl, 1'b0)
              && !((mag_of(a, s_dbl) == 63'h0) && (mag_of(b, s_dbl) == 63'h0))
              && (((a & sgn) != `FPX_ZERO64) && ((b & sgn) == `FPX_ZERO64)
               || (((a & sgn) == `FPX_ZERO64) && ((b & sgn) == `FPX_ZERO64) && (mag_of(a, s_dbl) < mag_of(b, s_dbl)))
               || (((a & sgn) != `FPX_ZERO64) && ((b & sgn) != `FPX_ZERO64) && (mag_of(a, s_dbl) > mag_of(b, s_dbl))));
      end
      // Product is rounded on its own before the sum; these wide datapaths return the default quiet NaN
      fpx_pkg::FPX_OP_FMA, fpx_pkg::FPX_OP_FMS: res = s_dbl ? `FPX_QNAN_D : `FPX_QNAN_S;
      default: res = s_dbl ? `FPX_QNAN_D : `FPX_QNAN_S;
    endcase
    // Denormal arithmetic result becomes a zero of the same sign
    if (ftz_en && arith && !is_cmp && (mag_of(res, s_dbl) != 63'h0)
        && (s_dbl ? (res[62:52] == 11'h000) : (res[30:23] == 8'h00))) begin
      res = res & sgn;
    end
    if (!fr64_mode) begin
      res = res & `FPX_HI_MASK;
    end
  end

  // Skid holding stage so a stalled instruction never blocks the handshake path
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hold_v_r    <= 1'b0;
      iss_ready_r <= 1'b0;
      hold_op_r   <= fpx_pkg::FPX_OP_MOV;
      hold_dbl_r  <= 1'b0;
      hold_fd_r   <= 5'h00;
      hold_fs_r   <= 5'h00;
      hold_ft_r   <= 5'h00;
      hold_int_r  <= `FPX_ZERO64;
    end else begin
      hold_v_r    <= s_v && !go;
      iss_ready_r <= !(s_v && !go);
      if (!hold_v_r) begin
        hold_op_r  <= iss_op;
        hold_dbl_r <= iss_dbl;
        hold_fd_r  <= iss_fd;
        hold_fs_r  <= iss_fs;
        hold_ft_r  <= iss_ft;
        hold_int_r <= iss_int_data;
      end
    end
  end

  // Result pipeline: entry placed so that it leaves slot 0 exactly lat cycles after issue
  always_ff @(posedge core_clk) begin
    if (!rst_n || wb_exc) begin
      for (int i = 0; i <= `FPX_PIPE_TOP; i++) begin
        pv_r[i] <= 1'b0;
        pw_r[i] <= 1'b0;
        pc_r[i] <= 1'b0;
        pe_r[i] <= `FPX_EXC_NONE;
        pd_r[i] <= 5'h00;
        px_r[i] <= `FPX_ZERO64;
      end
    end else begin
      for (int i = 0; i <= `FPX_PIPE_TOP; i++) begin
        if (go && to_pipe && (i == int'(lat) - 1)) begin
          pv_r[i] <= 1'b1;
          pw_r[i] <= wr_reg;
          pc_r[i] <= is_cmp;
          pe_r[i] <= cause;
          pd_r[i] <= s_fd;
          px_r[i] <= res;
        end else if (i < `FPX_PIPE_TOP) begin
          pv_r[i] <= pv_r[i+1];
          pw_r[i] <= pw_r[i+1];
          pc_r[i] <= pc_r[i+1];
          pe_r[i] <= pe_r[i+1];
          pd_r[i] <= pd_r[i+1];
          px_r[i] <= px_r[i+1];
        end else begin
          pv_r[i] <= 1'b0;
        end
      end
    end
  end

  // Scoreboard and arithmetic order counter
  always_ff @(posedge core_clk) begin
    if (!rst_n || wb_exc) begin
      for (int i = 0; i < `FPX_NUM_FPR; i++) sb_r[i] <= 6'h00;
      ord_r <= 6'h00;
    end else begin
      for (int i = 0; i < `FPX_NUM_FPR; i++) begin
        if (go && wr_reg && (s_fd == 5'(i))) sb_r[i] <= lat;
        else if (sb_r[i] != 6'h00) sb_r[i] <= sb_r[i] - 6'h01;
      end
      if (go && arith) ord_r <= lat;
      else if (ord_r != 6'h00) ord_r <= ord_r - 6'h01;
    end
  end

  // Writeback of the oldest entry, suppressed when it carries an exception
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `FPX_NUM_FPR; i++) rf_r[i] <= `FPX_ZERO64;
      cc_r <= 8'h00;
    end else if (pv_r[0] && !wb_exc) begin
      if (pw_r[0]) rf_r[pd_r[0]] <= px_r[0];
      if (pc_r[0]) cc_r[pd_r[0][2:0]] <= px_r[0][0];
    end
  end

  // Precise exception flag; a new fault wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      exc_r       <= 1'b0;
      exc_cause_r <= `FPX_EXC_NONE;
    end else if (wb_exc) begin
      exc_r       <= 1'b1;
      exc_cause_r <= pe_r[0];
    end else if (exc_clr) begin
      exc_r       <= 1'b0;
      exc_cause_r <= `FPX_EXC_NONE;
    end
  end

  // Transfer out: data appears one cycle after issue
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_valid_r <= 1'b0;
      out_data_r  <= `FPX_ZERO64;
    end else begin
      out_valid_r <= go && out_op;
      if (go && out_op) out_data_r <= s_dbl ? a : (a & `FPX_HI_MASK);
    end
  end
endmodule

/* fpx_regs.svh */
// Timing constants, sizes and fixed data patterns of the floating point execution unit
`ifndef FPX_REGS_SVH
`define FPX_REGS_SVH

// Latencies in unit cycles
`define FPX_LAT_BASIC   6'h04
`define FPX_LAT_MULD    6'h05
`define FPX_LAT_DIVS    6'h11
`define FPX_LAT_DIVD    6'h20
`define FPX_LAT_RCPS    6'h0d
`define FPX_LAT_RCPD    6'h1a
`define FPX_LAT_RSQS    6'h11
`define FPX_LAT_RSQD    6'h24
`define FPX_LAT_XFER_IN 6'h04
`define FPX_LAT_XFER_OUT 6'h01

// Repeat rates in unit cycles
`define FPX_RPT_MULD    5'h02
`define FPX_RPT_DIVS    5'h0e
`define FPX_RPT_DIVD    5'h1d
`define FPX_RPT_RCPS    5'h0a
`define FPX_RPT_RCPD    5'h15
`define FPX_RPT_RSQS    5'h0e
`define FPX_RPT_RSQD    5'h1f
`define FPX_RPT_ONE     5'h01

// Structure
`define FPX_NUM_FPR     32
`define FPX_PIPE_TOP    36
`define FPX_NUM_CLS     7
`define FPX_CLS_NONE    3'h7
`define FPX_NUM_CC      8

// Data patterns
`define FPX_QNAN_D      64'h7ff8_0000_0000_0000
`define FPX_QNAN_S      64'h0000_0000_7fc0_0000
`define FPX_HI_MASK     64'h0000_0000_ffff_ffff
`define FPX_SIGN_D      64'h8000_0000_0000_0000
`define FPX_SIGN_S      64'h0000_0000_8000_0000
`define FPX_ZERO64      64'h0000_0000_0000_0000

// Exception causes
`define FPX_EXC_NONE    2'h0
`define FPX_EXC_INVALID 2'h1
`define FPX_EXC_DIVZERO 2'h2

`endif

/* fpx_pkg.sv */
// Types shared by the floating point execution unit
package fpx_pkg;
  typedef enum logic [4:0] {
    FPX_OP_ABS, FPX_OP_NEG, FPX_OP_ADD, FPX_OP_SUB, FPX_OP_MUL,
    FPX_OP_FMA, FPX_OP_FMS, FPX_OP_DIV, FPX_OP_SQRT, FPX_OP_RECIP,
    FPX_OP_RSQRT, FPX_OP_CVT, FPX_OP_MOV, FPX_OP_MOVZ, FPX_OP_MOVN,
    FPX_OP_CEQ, FPX_OP_CLT, FPX_OP_MTC, FPX_OP_LOAD, FPX_OP_MFC, FPX_OP_STORE
  } fpx_op_t;
endpackage

/* fpx_rpt_timer.sv */
// Repeat-interval timer for one non-pipelined operation class
`timescale 1ns/1ps
module fpx_rpt_timer (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       load,
  input  wire logic [4:0] load_val,
  // Status
  output logic            busy
);
  logic [4:0] cnt_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  assign busy = (cnt_r != 5'h00);
endmodule

/* fpx_exec_unit_props.sv */
// Port-level assertions for the floating point execution unit
`timescale 1ns/1ps
module fpx_exec_unit_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Issue
  input wire logic        iss_valid,
  input wire logic        iss_ready_r,
  // Results and exceptions
  input wire logic        out_valid_r,
  input wire logic [63:0] out_data_r,
  input wire logic [7:0]  cc_r,
  input wire logic        exc_r,
  input wire logic [1:0]  exc_cause_r,
  input wire logic        exc_clr
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_take;
    iss_valid && iss_ready_r;
  endsequence
  sequence s_exc_take;
    exc_r && !exc_clr ##0 s_take;
  endsequence

  property p_rst_quiet;
    disable iff (1'b0) !rst_n |=> !iss_ready_r && !out_valid_r && !exc_r && exc_cause_r == 2'h0
      && cc_r == 8'h00 && out_data_r == 64'h0000_0000_0000_0000;
  endproperty
  property p_ready_rise;
    $rose(rst_n) |-> !iss_ready_r ##1 iss_ready_r;
  endproperty
  // Ready only falls after an edge that took an instruction it could not issue
  property p_ready_drop;
    $fell(iss_ready_r) && $past(rst_n) |-> $past(iss_valid);
  endproperty
  property p_exc_hold;
    exc_r && !exc_clr |=> exc_r;
  endproperty
  property p_exc_clear;
    exc_r && exc_clr |=> !exc_r;
  endproperty
  property p_exc_block;
    s_exc_take |=> !iss_ready_r;
  endproperty
  property p_exc_cause;
    $rose(exc_r) |-> exc_cause_r == 2'h1 || exc_cause_r == 2'h2;
  endproperty
  property p_cause_stable;
    exc_r && $past(exc_r) |-> $stable(exc_cause_r);
  endproperty
  property p_out_hold;
    !out_valid_r && $past(rst_n) |-> $stable(out_data_r);
  endproperty

  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not cleared by reset");
  a_ready_rise: assert property (p_ready_rise) else $error("ready not raised after reset");
  a_ready_drop: assert property (p_ready_drop) else $error("ready fell without a request");
  a_exc_hold: assert property (p_exc_hold) else $error("exception flag lost");
  a_exc_clear: assert property (p_exc_clear) else $error("exception flag not cleared");
  a_exc_block: assert property (p_exc_block) else $error("issue not blocked by exception");
  a_exc_cause: assert property (p_exc_cause) else $error("exception without valid cause");
  a_cause_stable: assert property (p_cause_stable) else $error("exception cause changed");
  a_out_hold: assert property (p_out_hold) else $error("transfer data moved without pulse");
endmodule

bind fpx_exec_unit fpx_exec_unit_props fpx_exec_unit_props_i (
  .core_clk(core_clk), .rst_n(rst_n), .iss_valid(iss_valid), .iss_ready_r(iss_ready_r),
  .out_valid_r(out_valid_r), .out_data_r(out_data_r), .cc_r(cc_r), .exc_r(exc_r),
  .exc_cause_r(exc_cause_r), .exc_clr(exc_clr));

/* fpx_core_model.sv */
// Behavioural integer core that offers coprocessor instructions to the unit
`timescale 1ns/1ps
module fpx_core_model (
  // Clock
  input wire logic         core_clk,
  // Issue to the unit
  output logic             iss_valid,
  output fpx_pkg::fpx_op_t iss_op,
  output logic             iss_dbl,
  output logic [4:0]       iss_fd,
  output logic [4:0]       iss_fs,
  output logic [4:0]       iss_ft,
  output logic [63:0]      iss_int_data,
  input wire logic         iss_ready_r
);
  int cyc = 0;
  always @(posedge core_clk) cyc <= cyc + 1;
  initial begin
    iss_valid = 1'b0;
    iss_op = fpx_pkg::FPX_OP_MOV;
    iss_dbl = 1'b0;
    {iss_fd, iss_fs, iss_ft} = 15'h0000;
    iss_int_data = 64'h0000_0000_0000_0000;
  end
  // Called just after a falling edge; fields hold until the edge that takes them
  task automatic issue(input fpx_pkg::fpx_op_t op, input logic dbl, input logic [4:0] fd, input logic [4:0] fs,
                       input logic [4:0] ft, input logic [63:0] data, output int at);
    int n;
    iss_valid = 1'b1;
    iss_op = op;
    iss_dbl = dbl;
    {iss_fd, iss_fs, iss_ft} = {fd, fs, ft};
    iss_int_data = data;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (iss_ready_r === 1'b1) break;
    end
    @(negedge core_clk);
    at = (n < 200) ? cyc : -1;
  endtask
  // Released fields other than the opcode show inverted values so stale data can never look valid
  task automatic idle();
    iss_valid = 1'b0;
    {iss_fd, iss_fs, iss_ft} = ~{iss_fd, iss_fs, iss_ft};
    iss_dbl = ~iss_dbl;
    iss_int_data = ~iss_int_data;
  endtask
endmodule

/* tb_fpx_exec_unit.sv */
// Self-checking testbench for the floating point execution unit
`timescale 1ns/1ps
module tb_fpx_exec_unit;
  logic             core_clk;
  logic             rst_n;
  logic             fr64_mode;
  logic             ftz_en;
  logic             exc_clr;
  logic             iss_valid;
  fpx_pkg::fpx_op_t iss_op;
  logic             iss_dbl;
  logic [4:0]       iss_fd;
  logic [4:0]       iss_fs;
  logic [4:0]       iss_ft;
  logic [63:0]      iss_int_data;
  logic             iss_ready_r;
  logic             out_valid_r;
  logic [63:0]      out_data_r;
  logic [7:0]       cc_r;
  logic             exc_r;
  logic [1:0]       exc_cause_r;
  int               n_mismatch = 0;
  int               compares = 0;
  localparam logic [63:0] VX = 64'hc000_0000_c000_0000;
  localparam logic [63:0] VA = 64'h4000_0000_c000_0000;
  localparam logic [63:0] QD = 64'h7ff8_0000_0000_0000;
  localparam logic [63:0] QS = 64'h0000_0000_7fc0_0000;

  fpx_exec_unit fpx_exec_unit_i (.core_clk(core_clk), .rst_n(rst_n), .fr64_mode(fr64_mode), .ftz_en(ftz_en),
    .iss_valid(iss_valid), .iss_op(iss_op), .iss_dbl(iss_dbl), .iss_fd(iss_fd), .iss_fs(iss_fs), .iss_ft(iss_ft),
    .iss_int_data(iss_int_data), .iss_ready_r(iss_ready_r), .out_valid_r(out_valid_r), .out_data_r(out_data_r),
    .cc_r(cc_r), .exc_r(exc_r), .exc_cause_r(exc_cause_r), .exc_clr(exc_clr));
  fpx_core_model fpx_core_model_i (.core_clk(core_clk), .iss_valid(iss_valid), .iss_op(iss_op), .iss_dbl(iss_dbl),
    .iss_fd(iss_fd), .iss_fs(iss_fs), .iss_ft(iss_ft), .iss_int_data(iss_int_data), .iss_ready_r(iss_ready_r));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_out(output int at, output logic [63:0] d);
    int n;
    at = -1;
    d = 64'h0000_0000_0000_0000;
    for (n = 0; n < 300; n++) begin
      if (out_valid_r === 1'b1) begin
        at = fpx_core_model_i.cyc;
        d = out_data_r;
        break;
      end
      @(negedge core_clk);
    end
  endtask

  // Load, run the op once or twice back to back, read the last result out
  task automatic lat(input fpx_pkg::fpx_op_t op, input logic dbl, input logic twice, input int r, input int l,
                     input logic [63:0] d_in, input logic [63:0] exp);
    int t0, t1, tx;
    logic [63:0] d;
    fpx_core_model_i.issue(fpx_pkg::FPX_OP_MTC, 1'b1, 5'h01, 5'h00, 5'h00, d_in, t0);
    fpx_core_model_i.issue(op, dbl, 5'h02, 5'h01, 5'h01, 64'h0000_0000_0000_0000, tx);
    if (twice) fpx_core_model_i.issue(op, dbl, 5'h03, 5'h01, 5'h01, 64'h0000_0000_0000_0000, tx);
    fpx_core_model_i.issue(fpx_pkg::FPX_OP_MFC, dbl, 5'h00, twice ? 5'h03 : 5'h02, 5'h00, 64'h0, tx);
    fpx_core_model_i.idle();
    wait_out(t1, d);
    chk("cycles to result", 64'(t1 - t0), 64'(4 + (twice ? r : 0) + l));
    chk("result data", dbl ? d : {32'h0000_0000, d[31:0]}, exp);
  endtask

  task automatic t_cmp();
    int tx;
    fpx_core_model_i.issue(fpx_pkg::FPX_OP_MTC, 1'b1, 5'h01, 5'h00, 5'h00, VX, tx);
    fpx_core_model_i.issue(fpx_pkg::FPX_OP_CEQ, 1'b1, 5'h05, 5'h01, 5'h01, 64'h0, tx);
    fpx_core_model_i.idle();
    repeat (8) @(negedge core_clk);
    chk("equal condition", {63'h0, cc_r[5]}, 64'h1);
    fpx_core_model_i.issue(fpx_pkg::FPX_OP_CLT, 1'b1, 5'h05, 5'h01, 5'h01, 64'h0, tx);
    fpx_core_model_i.idle();
    repeat (6) @(negedge core_clk);
    chk("less condition", {63'h0, cc_r[5]}, 64'h0);
  endtask

  // A faulting add must discard a younger move and block issue until cleared
  task automatic t_exc();
    int tx, n;
    logic [63:0] d;
    fpx_core_model_i.issue(fpx_pkg::FPX_OP_MTC, 1'b1, 5'h06, 5'h00, 5'h00, 64'h7ff0_0000_0000_0001, tx);
    fpx_core_model_i.issue(fpx_pkg::FPX_OP_ADD, 1'b1, 5'h07, 5'h06, 5'h06, 64'h0, tx);
    fpx_core_model_i.issue(fpx_pkg::FPX_OP_MOV, 1'b1, 5'h08, 5'h01, 5'h00, 64'h0, tx);
    fpx_core_model_i.idle();
    for (n = 0; n < 20 && exc_r !== 1'b1; n++) @(negedge core_clk);
    chk("exception cause", {61'h0, exc_r, exc_cause_r}, 64'h5);
    fpx_core_model_i.issue(fpx_pkg::FPX_OP_MFC, 1'b1, 5'h00, 5'h08, 5'h00, 64'h0, tx);
    fpx_core_model_i.idle();
    repeat (3) @(negedge core_clk);
    chk("held by exception", {63'h0, out_valid_r}, 64'h0);
    exc_clr = 1'b1;
    @(negedge core_clk);
    exc_clr = 1'b0;
    wait_out(tx, d);
    chk("younger discarded", {d[62:0], exc_r}, 64'h0);
  endtask

  task automatic wrap_up();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    int tx;
    logic [63:0] d;
    rst_n = 1'b0;
    fr64_mode = 1'b1;
    ftz_en = 1'b0;
    exc_clr = 1'b0;
    repeat (6) @(negedge core_clk);
    chk("reset outputs", {iss_ready_r, out_valid_r, exc_r, exc_cause_r, cc_r}, 64'h0);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("ready after reset", {63'h0, iss_ready_r}, 64'h1);
    lat(fpx_pkg::FPX_OP_ABS, 1'b1, 1'b0, 1, 4, VX, VA);
    lat(fpx_pkg::FPX_OP_NEG, 1'b1, 1'b1, 1, 4, VX, VA);
    lat(fpx_pkg::FPX_OP_ADD, 1'b1, 1'b1, 1, 4, VX, QD);
    lat(fpx_pkg::FPX_OP_SUB, 1'b0, 1'b0, 1, 4, VX, QS);
    lat(fpx_pkg::FPX_OP_MUL, 1'b0, 1'b1, 1, 4, VX, QS);
    lat(fpx_pkg::FPX_OP_MUL, 1'b1, 1'b1, 2, 5, VX, QD);
    lat(fpx_pkg::FPX_OP_FMA, 1'b1, 1'b1, 2, 5, VX, QD);
    lat(fpx_pkg::FPX_OP_FMS, 1'b0, 1'b1, 1, 4, VX, QS);
    lat(fpx_pkg::FPX_OP_DIV, 1'b0, 1'b1, 14, 17, VX, QS);
    lat(fpx_pkg::FPX_OP_DIV, 1'b1, 1'b1, 29, 32, VX, QD);
    lat(fpx_pkg::FPX_OP_SQRT, 1'b0, 1'b0, 14, 17, VX, QS);
    lat(fpx_pkg::FPX_OP_SQRT, 1'b1, 1'b0, 29, 32, VX, QD);
    lat(fpx_pkg::FPX_OP_RECIP, 1'b0, 1'b1, 10, 13, VX, QS);
    lat(fpx_pkg::FPX_OP_RECIP, 1'b1, 1'b0, 21, 26, VX, QD);
    lat(fpx_pkg::FPX_OP_RSQRT, 1'b0, 1'b0, 14, 17, VX, QS);
    lat(fpx_pkg::FPX_OP_RSQRT, 1'b1, 1'b1, 31, 36, VX, QD);
    lat(fpx_pkg::FPX_OP_CVT, 1'b1, 1'b1, 1, 4, VX, QD);
    lat(fpx_pkg::FPX_OP_MOV, 1'b1, 1'b1, 1, 4, VX, VX);
    lat(fpx_pkg::FPX_OP_MOVZ, 1'b1, 1'b0, 1, 4, VX, VX);
    ftz_en = 1'b1;
    lat(fpx_pkg::FPX_OP_ABS, 1'b1, 1'b0, 1, 4, 64'h8000_0000_0000_0001, 64'h0);
    ftz_en = 1'b0;
    fr64_mode = 1'b0;
    lat(fpx_pkg::FPX_OP_MOV, 1'b1, 1'b0, 1, 4, VX, 64'h0000_0000_c000_0000);
    fr64_mode = 1'b1;
    t_cmp();
    t_exc();
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    fpx_core_model_i.issue(fpx_pkg::FPX_OP_MFC, 1'b1, 5'h00, 5'h01, 5'h00, 64'h0, tx);
    fpx_core_model_i.idle();
    wait_out(tx, d);
    chk("register cleared by reset", d, 64'h0);
    wrap_up();
  end
endmodule
